// ---- rtl/blit_pkg.sv ----
/*
 * constants shared by the block-move engine: register offsets, field
 * positions, reset values and step sizes.
 * assumes a 32-bit classic wishbone register bus and a 16-bit memory port.
 */
`default_nettype none
package blit_pkg;
	// ---------------------------------------------------------------
	// bus and memory widths
	// ---------------------------------------------------------------
	localparam int WB_ADDR_W = 8;
	localparam int WB_DATA_W = 32;
	localparam int MEM_ADDR_W = 24;
	localparam int WORD_W = 16;

	// ---------------------------------------------------------------
	// register byte offsets
	// ---------------------------------------------------------------
	localparam logic [WB_ADDR_W-1:0] OFS_CONTROL = 8'h00;
	localparam logic [WB_ADDR_W-1:0] OFS_SIZE = 8'h04;
	localparam logic [WB_ADDR_W-1:0] OFS_STATUS = 8'h08;
	localparam logic [WB_ADDR_W-1:0] OFS_PTR_BASE = 8'h10; // four words, one per channel
	localparam logic [WB_ADDR_W-1:0] OFS_MOD_BASE = 8'h20;
	localparam logic [WB_ADDR_W-1:0] OFS_DAT_BASE = 8'h30; // three source data words

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int CTL_LF_LSB = 0;
	localparam int CTL_LF_W = 8;
	localparam int CTL_EN_LSB = 8; // bits 8..11: source one/two/three, target
	localparam int NUM_CH = 4;
	localparam int NUM_SRC = 3;
	localparam int CH_TARGET = 3;
	localparam int SIZE_W_BITS = 6;
	localparam int SIZE_H_LSB = 6;
	localparam int SIZE_H_BITS = 10;
	localparam int STAT_DONE_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;

	// ---------------------------------------------------------------
	// reset values and steps
	// ---------------------------------------------------------------
	localparam logic [WB_DATA_W-1:0] CTL_RESET = 32'h0000_0000;
	localparam logic [MEM_ADDR_W-1:0] PTR_STEP = 24'h00_0002;
	localparam logic [WB_DATA_W-1:0] READ_ZERO = 32'h0000_0000;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FETCH,
		ST_WRITE,
		ST_ADVANCE
	} blit_state_e;
endpackage : blit_pkg
`default_nettype wire

// ---- rtl/blit_func_gen.sv ----
/*
 * three-input function generator: one minterm byte selects each output bit.
 * assumes operands stable for the cycle in which the result is sampled.
 */
`default_nettype none
module blit_func_gen #(
	parameter int W = 16
) (
	input wire logic [7:0] logic_function_byte_i,
	input wire logic [W-1:0] src_one_i,
	input wire logic [W-1:0] src_two_i,
	input wire logic [W-1:0] src_three_i,
	output logic [W-1:0] result_o
);
	// ---------------------------------------------------------------
	// per-bit minterm lookup
	// ---------------------------------------------------------------
	// same function for every bit position of every word
	always_comb begin
		for (int i = 0; i < W; i++) begin
			result_o[i] = logic_function_byte_i[{src_one_i[i], src_two_i[i], src_three_i[i]}];
		end
	end
endmodule : blit_func_gen
`default_nettype wire

// ---- rtl/blit_addr_step.sv ----
/*
 * address stepper for one channel: advances by a word, or by a word plus
 * the sign-extended row modulo at the end of a row.
 * assumes it is combinational and sampled by the owner's pointer register.
 */
`default_nettype none
module blit_addr_step
	import blit_pkg::*;
(
	input wire logic [blit_pkg::MEM_ADDR_W-1:0] ptr_i,
	input wire logic [blit_pkg::WORD_W-1:0] modulo_i,
	input wire logic row_end_i,
	output logic [blit_pkg::MEM_ADDR_W-1:0] ptr_next_o
);
	logic [MEM_ADDR_W-1:0] mod_ext;
	logic [MEM_ADDR_W-1:0] stepped;

	// ---------------------------------------------------------------
	// step arithmetic
	// ---------------------------------------------------------------
	// low modulo bit dropped so pointer stays even
	assign mod_ext = {{(MEM_ADDR_W-WORD_W){modulo_i[WORD_W-1]}}, modulo_i[WORD_W-1:1], 1'b0};
	assign stepped = ptr_i + PTR_STEP;
	assign ptr_next_o = row_end_i ? (stepped + mod_ext) : stepped;
endmodule : blit_addr_step
`default_nettype wire

// ---- rtl/rect_block_move_dma.sv ----
/*
 * rectangular block-move engine: register file on wishbone, a word-at-a-time
 * walker over three sources and one target, and the function generator.
 * assumes a memory arbiter that grants one 16-bit access per mem_ack_i and
 * answers reads with data valid together with mem_ack_i.
 */
// The placing of the registers and the Wishbone slave port were left to the implementer.
//
// Function
// - four separate channel enable bits in the first control register.
// - disabled channel makes no memory cycle; disabled source uses its data word.
// - source data registers are writable by software as preloads.
// - one 16-bit word per access, only while the bus is granted.
// - completion sets a done flag and raises an interrupt request.
// - one shared size register for all channels.
// - width is low six bits; zero means 64 words.
// - height is upper ten bits; zero means 1024 rows.
// - pointer of an enabled channel advances by two per word.
// - signed modulo added to pointer at each row end.
// - each channel has its own 16-bit modulo register.
// - modulo in bytes, low bit ignored, sign-extended.
// - 256 logic combinations of three sources are available.
// - same function applied to every bit of every word.
// - each of eight source combinations maps to a programmable bit.
// - writing the size register starts the operation.
// - logic function byte sits in the first control register.
// - pointer low bit ignored; transfers are word aligned.
`default_nettype none
module rect_block_move_dma
	import blit_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [blit_pkg::WB_ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [blit_pkg::WB_DATA_W-1:0] wb_dat_i,
	output logic [blit_pkg::WB_DATA_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	output logic mem_req_o,
	output logic mem_we_o,
	output logic [blit_pkg::MEM_ADDR_W-1:0] mem_addr_o,
	output logic [blit_pkg::WORD_W-1:0] mem_wdata_o,
	input wire logic mem_ack_i,
	input wire logic [blit_pkg::WORD_W-1:0] mem_rdata_i,
	output logic done_o,
	output logic irq_o
);
	import blit_pkg::*;

	// ---------------------------------------------------------------
	// address decode fields
	// ---------------------------------------------------------------
	// registers sit on word boundaries, up to four to each sixteen-byte block
	localparam int IDX_LSB = 2;
	localparam int IDX_W = 2;
	localparam int BLOCK_LSB = 4;

	// ---------------------------------------------------------------
	// register storage
	// ---------------------------------------------------------------
	logic [WB_DATA_W-1:0] control_reg;
	logic [WORD_W-1:0] size_reg;
	logic [MEM_ADDR_W-1:0] ptr_reg [NUM_CH];
	logic [WORD_W-1:0] mod_reg [NUM_CH];
	logic [WORD_W-1:0] dat_reg [NUM_SRC];
	logic done_reg;
	logic irq_reg;

	// ---------------------------------------------------------------
	// walker state
	// ---------------------------------------------------------------
	blit_state_e state_reg;
	logic [1:0] ch_reg;
	logic [SIZE_W_BITS:0] col_reg;
	logic [SIZE_H_BITS:0] row_reg;
	logic [SIZE_W_BITS:0] width_words;
	logic [SIZE_H_BITS:0] height_rows;
	logic [WORD_W-1:0] result;
	logic [MEM_ADDR_W-1:0] ptr_next [NUM_CH];
	logic row_end;
	logic last_word;
	logic [7:0] lf_byte;
	logic [NUM_CH-1:0] enables;

	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	logic bus_hit;
	logic bus_wr;
	logic [1:0] bus_idx;
	logic size_wr;
	logic busy;
	logic ptr_blk;
	logic mod_blk;
	logic dat_blk;

	// both low byte lanes required, so a byte write cannot tear a register
	assign bus_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign bus_wr = bus_hit && wb_we_i && wb_sel_i[0] && wb_sel_i[1];
	assign bus_idx = wb_adr_i[IDX_LSB +: IDX_W];
	assign ptr_blk = (wb_adr_i[WB_ADDR_W-1:BLOCK_LSB] == OFS_PTR_BASE[WB_ADDR_W-1:BLOCK_LSB]);
	assign mod_blk = (wb_adr_i[WB_ADDR_W-1:BLOCK_LSB] == OFS_MOD_BASE[WB_ADDR_W-1:BLOCK_LSB]);
	assign dat_blk = (wb_adr_i[WB_ADDR_W-1:BLOCK_LSB] == OFS_DAT_BASE[WB_ADDR_W-1:BLOCK_LSB])
		&& (bus_idx != 2'(CH_TARGET));
	assign busy = (state_reg != ST_IDLE);
	assign size_wr = bus_wr && (wb_adr_i == OFS_SIZE) && !busy;
	assign lf_byte = control_reg[CTL_LF_LSB +: CTL_LF_W];
	assign enables = control_reg[CTL_EN_LSB +: NUM_CH];

	// zero field codes the maximum extent
	assign width_words = (size_reg[SIZE_W_BITS-1:0] == '0) ?
		{1'b1, {SIZE_W_BITS{1'b0}}} : {1'b0, size_reg[SIZE_W_BITS-1:0]};
	assign height_rows = (size_reg[WORD_W-1:SIZE_H_LSB] == '0) ?
		{1'b1, {SIZE_H_BITS{1'b0}}} : {1'b0, size_reg[WORD_W-1:SIZE_H_LSB]};
	assign row_end = (col_reg == width_words - 1'b1);
	assign last_word = row_end && (row_reg == height_rows - 1'b1);

	// ---------------------------------------------------------------
	// wishbone answer: one-cycle ack, registered read data
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= READ_ZERO;
		end else begin
			wb_ack_o <= bus_hit;
			wb_dat_o <= READ_ZERO;
			if (bus_hit && !wb_we_i) begin
				// size and modulo are write-only; unmapped reads give zero
				if (wb_adr_i == OFS_CONTROL) begin
					wb_dat_o <= control_reg;
				end else if (wb_adr_i == OFS_STATUS) begin
					wb_dat_o <= READ_ZERO | (WB_DATA_W'(done_reg) << STAT_DONE_BIT)
						| (WB_DATA_W'(busy) << STAT_BUSY_BIT);
				end else if (ptr_blk) begin
					wb_dat_o <= WB_DATA_W'(ptr_reg[bus_idx]);
				end else if (dat_blk) begin
					wb_dat_o <= WB_DATA_W'(dat_reg[bus_idx]);
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// control and size registers
	// ---------------------------------------------------------------
	// control writes ignored mid-operation so the function stays fixed
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			control_reg <= CTL_RESET;
			size_reg <= '0;
		end else begin
			if (bus_wr && (wb_adr_i == OFS_CONTROL) && !busy) begin
				control_reg <= wb_dat_i;
			end
			if (size_wr) begin
				size_reg <= wb_dat_i[WORD_W-1:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// modulo and source data registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NUM_CH; i++) begin
				mod_reg[i] <= '0;
			end
			for (int i = 0; i < NUM_SRC; i++) begin
				dat_reg[i] <= '0;
			end
		end else begin
			if (bus_wr && !busy && mod_blk) begin
				mod_reg[bus_idx] <= wb_dat_i[WORD_W-1:0];
			end
			if (bus_wr && !busy && dat_blk) begin
				dat_reg[bus_idx] <= wb_dat_i[WORD_W-1:0];
			end else if (state_reg == ST_FETCH && mem_ack_i && ch_reg != 2'(CH_TARGET)) begin
				dat_reg[ch_reg] <= mem_rdata_i;
			end
		end
	end

	// ---------------------------------------------------------------
	// address steppers, one per channel
	// ---------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_step
			blit_addr_step u_step (
				.ptr_i(ptr_reg[g]),
				.modulo_i(mod_reg[g]),
				.row_end_i(row_end),
				.ptr_next_o(ptr_next[g])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// pointer registers
	// ---------------------------------------------------------------
	// pointer advances only after its own access, so disabled ones hold
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NUM_CH; i++) begin
				ptr_reg[i] <= '0;
			end
		end else begin
			if (bus_wr && !busy && ptr_blk) begin
				ptr_reg[bus_idx] <= {wb_dat_i[MEM_ADDR_W-1:1], 1'b0};
			end else if (state_reg == ST_ADVANCE) begin
				for (int i = 0; i < NUM_CH; i++) begin
					if (enables[i]) begin
						ptr_reg[i] <= ptr_next[i];
					end
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// function generator
	// ---------------------------------------------------------------
	blit_func_gen #(
		.W(WORD_W)
	) u_func (
		.logic_function_byte_i(lf_byte),
		.src_one_i(dat_reg[0]),
		.src_two_i(dat_reg[1]),
		.src_three_i(dat_reg[2]),
		.result_o(result)
	);

	// ---------------------------------------------------------------
	// walker: fetch enabled sources in order, then write target
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
			ch_reg <= '0;
			col_reg <= '0;
			row_reg <= '0;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (size_wr) begin
						state_reg <= ST_FETCH;
						ch_reg <= '0;
						col_reg <= '0;
						row_reg <= '0;
					end
				end
				ST_FETCH: begin
					// skip disabled channels without a memory cycle
					if (!enables[ch_reg] || mem_ack_i) begin
						if (ch_reg == 2'(NUM_SRC - 1)) begin
							state_reg <= ST_WRITE;
						end else begin
							ch_reg <= ch_reg + 2'd1;
						end
					end
				end
				ST_WRITE: begin
					if (!enables[CH_TARGET] || mem_ack_i) begin
						state_reg <= ST_ADVANCE;
					end
				end
				ST_ADVANCE: begin
					// pointers step on this same edge, ready for the next fetch
					ch_reg <= '0;
					if (last_word) begin
						state_reg <= ST_IDLE;
					end else if (row_end) begin
						col_reg <= '0;
						row_reg <= row_reg + 1'b1;
						state_reg <= ST_FETCH;
					end else begin
						col_reg <= col_reg + 1'b1;
						state_reg <= ST_FETCH;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// memory request outputs, registered
	// ---------------------------------------------------------------
	// request drops the cycle after ack so one ack is one word
	// write data re-driven each cycle; sources cannot change in ST_WRITE
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mem_req_o <= 1'b0;
			mem_we_o <= 1'b0;
			mem_addr_o <= '0;
			mem_wdata_o <= '0;
		end else begin
			mem_req_o <= 1'b0;
			if (state_reg == ST_FETCH && enables[ch_reg] && !mem_ack_i && !mem_req_o) begin
				mem_req_o <= 1'b1;
				mem_we_o <= 1'b0;
				mem_addr_o <= ptr_reg[ch_reg];
			end else if (state_reg == ST_FETCH && enables[ch_reg] && mem_req_o && !mem_ack_i) begin
				mem_req_o <= 1'b1;
			end else if (state_reg == ST_WRITE && enables[CH_TARGET] && !mem_ack_i) begin
				mem_req_o <= 1'b1;
				mem_we_o <= 1'b1;
				mem_addr_o <= ptr_reg[CH_TARGET];
				mem_wdata_o <= result;
			end
		end
	end

	// ---------------------------------------------------------------
	// completion flag and interrupt
	// ---------------------------------------------------------------
	// completion set outranks the clear by a fresh start
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			done_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else if (state_reg == ST_ADVANCE && last_word) begin
			done_reg <= 1'b1;
			irq_reg <= 1'b1;
		end else if (size_wr) begin
			done_reg <= 1'b0;
			irq_reg <= 1'b0;
		end
	end

	// flags leave straight from their registers
	assign done_o = done_reg;
	assign irq_o = irq_reg;
endmodule : rect_block_move_dma
`default_nettype wire

// ---- sim/blit_mem_model.sv ----
/*
 * graphics memory behind the engine's arbitrated port; logs target writes.
 * assumes one request at a time and data valid together with the ack.
 */
`default_nettype none
module blit_mem_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req_i,
	input wire logic we_i,
	input wire logic [23:0] addr_i,
	input wire logic [15:0] wdata_i,
	output logic ack_o,
	output logic [15:0] rdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] wait_reg;
	logic [3:0] turn_reg;
	int nrd;
	logic [23:0] wa[$];
	logic [15:0] wd[$];
	// grant after 0..3 cycles in turn, so prompt and slow answers both occur
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			wait_reg <= 2'h0;
			turn_reg <= 4'h0;
			rdata_o <= 16'h0;
		end else if (ack_o) begin
			ack_o <= 1'b0;
			rdata_o <= ~rdata_o; // stale data never lingers
		end else if (req_i && wait_reg >= turn_reg[1:0]) begin
			ack_o <= 1'b1;
			wait_reg <= 2'h0;
			turn_reg <= turn_reg + 4'h1;
			if (we_i) begin
				wa.push_back(addr_i);
				wd.push_back(wdata_i);
			end else begin
				nrd <= nrd + 1;
				rdata_o <= addr_i[15:0] ^ 16'h3c5a;
			end
		end else begin
			wait_reg <= req_i ? wait_reg + 2'h1 : 2'h0;
			rdata_o <= ~rdata_o;
		end
	end
endmodule : blit_mem_model
`default_nettype wire

// ---- sim/rect_block_move_dma_assertions.sv ----
/*
 * port checker for the block-move engine.
 * assumes it is bound onto rect_block_move_dma with one clock.
 */
`default_nettype none
module rect_block_move_dma_assertions
	import blit_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [blit_pkg::WB_ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [blit_pkg::WB_DATA_W-1:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic mem_req_o,
	input wire logic mem_we_o,
	input wire logic [blit_pkg::MEM_ADDR_W-1:0] mem_addr_o,
	input wire logic [blit_pkg::WORD_W-1:0] mem_wdata_o,
	input wire logic mem_ack_i,
	input wire logic done_o,
	input wire logic irq_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic size_wr;
	// size write taken this cycle
	assign size_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == OFS_SIZE
		&& wb_sel_i[0] && wb_sel_i[1];
	a_ack_taken: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acked");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == '0) else $error("read data idle");
	a_req_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o)
		&& $stable(mem_we_o) && $stable(mem_wdata_o)) else $error("access not held");
	a_req_drop: assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
		else $error("request after grant");
	a_addr_even: assert property (mem_req_o |-> !mem_addr_o[0]) else $error("odd address");
	a_irq_done: assert property (irq_o == done_o) else $error("irq differs from done");
	a_done_clear: assert property (size_wr && done_o |=> !done_o) else $error("done kept");
	a_done_idle: assert property (done_o |-> !mem_req_o) else $error("access after done");
	a_done_hold: assert property (done_o && !size_wr |=> done_o) else $error("done lost");
	c_write: cover property (mem_req_o && mem_ack_i && mem_we_o);
	c_slow: cover property (mem_req_o && !mem_ack_i ##1 mem_req_o && mem_ack_i);
	c_done: cover property ($rose(done_o));
endmodule : rect_block_move_dma_assertions
bind rect_block_move_dma rect_block_move_dma_assertions chk (.clk_i, .rst_i, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .mem_req_o, .mem_we_o,
	.mem_addr_o, .mem_wdata_o, .mem_ack_i, .done_o, .irq_o);
`default_nettype wire

// ---- sim/rect_block_move_dma_tb.sv ----
/*
 * self-checking bench: wishbone register tasks and blits against the model.
 * assumes the bound checker and the memory model beside the engine.
 */
`default_nettype none
module rect_block_move_dma_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import blit_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rd;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, mem_req_o, mem_we_o, mem_ack_i, done_o, irq_o;
	logic [23:0] mem_addr_o;
	logic [15:0] mem_wdata_o, mem_rdata_i;
	logic [7:0] lf[6] = '{8'h00, 8'hff, 8'hca, 8'h80, 8'h5a, 8'hf0};
	logic [23:0] da[4] = '{24'h200, 24'h202, 24'h202, 24'h204};
	logic [15:0] sa[4] = '{16'h100, 16'h102, 16'h108, 16'h10a};
	int n_errors = 0;
	int comparisons = 0;
	`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
		$display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
	initial forever #2.5 clk_i = ~clk_i;
	rect_block_move_dma DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
		.mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i),
		.mem_rdata_i(mem_rdata_i), .done_o(done_o), .irq_o(irq_o));
	blit_mem_model mem (.clk_i(clk_i), .rst_i(rst_i), .req_i(mem_req_o), .we_i(mem_we_o),
		.addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
	// one classic cycle, held until ack is sampled; unused bits always zero
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		// registered ack: taken one edge after the request is set, seen at the next
		`CHK(n, 2)
	endtask : wb
	// start by size write, wait for completion under a bound
	task blit(input logic [31:0] ctl, input logic [15:0] size);
		mem.wa.delete();
		mem.wd.delete();
		mem.nrd = 0;
		wb(1'b1, OFS_CONTROL, ctl);
		wb(1'b1, OFS_SIZE, {16'h0, size});
		`CHK(done_o, 1'b0)
		for (int n = 0; n < 20000 && done_o !== 1'b1; n++) @(posedge clk_i);
		`CHK(done_o, 1'b1)
		`CHK(irq_o, 1'b1)
		wb(1'b0, OFS_STATUS, 32'h0);
		`CHK(rd, 32'h1)
	endtask : blit
	task wrap_up;
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	// watchdog well beyond the longest blit
	initial begin
		#300000;
		n_errors++;
		wrap_up;
	end
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, OFS_CONTROL, 32'h0);
		`CHK(rd, CTL_RESET)
		wb(1'b0, OFS_SIZE, 32'h0);
		`CHK(rd, 32'h0)
		wb(1'b0, 8'h80, 32'h0);
		`CHK(rd, 32'h0)
		$display("test reset done");
		// copy from source one, odd target pointer and modulo low bit set
		wb(1'b1, OFS_PTR_BASE, 32'h100);
		wb(1'b1, OFS_PTR_BASE + 8'd12, 32'h201);
		wb(1'b1, OFS_MOD_BASE, 32'h5);
		wb(1'b1, OFS_MOD_BASE + 8'd12, 32'hfffe);
		blit(32'h09f0, 16'h0082);
		`CHK(mem.nrd, 4)
		for (int i = 0; i < 4; i++) begin
			`CHK(mem.wa[i], da[i])
			`CHK(mem.wd[i], sa[i] ^ 16'h3c5a)
		end
		wb(1'b0, OFS_PTR_BASE, 32'h0);
		`CHK(rd, 32'h110)
		$display("test copy done");
		// disabled sources act as constants through each of the six function bytes in lf
		wb(1'b1, OFS_DAT_BASE, 32'hf0f0);
		wb(1'b1, OFS_DAT_BASE + 8'd4, 32'hcccc);
		wb(1'b1, OFS_DAT_BASE + 8'd8, 32'haaaa);
		foreach (lf[i]) begin
			wb(1'b1, OFS_PTR_BASE + 8'd12, 32'h300);
			blit({24'h000008, lf[i]}, 16'h0041);
			`CHK(mem.nrd, 0)
			`CHK(mem.wa[0], 24'h300)
			`CHK(mem.wd[0], {lf[i], lf[i]})
		end
		wb(1'b0, OFS_DAT_BASE + 8'd4, 32'h0);
		`CHK(rd, 32'hcccc)
		$display("test function done");
		// stored zero width and zero height
		wb(1'b1, OFS_MOD_BASE + 8'd12, 32'h0);
		wb(1'b1, OFS_PTR_BASE + 8'd12, 32'h400);
		blit(32'h08ff, 16'h0040);
		`CHK(mem.wa.size(), 64)
		`CHK(mem.wa[63], 24'h47e)
		wb(1'b1, OFS_PTR_BASE + 8'd12, 32'h1000);
		blit(32'h08ff, 16'h0001);
		`CHK(mem.wa.size(), 1024)
		`CHK(mem.wa[1023], 24'h17fe)
		$display("test size done");
		wrap_up;
	end
endmodule : rect_block_move_dma_tb
`default_nettype wire
